//--- common/fsg_pkg.sv
// Constants and carrier types of the frame-synchronised gain configuration bank.
package fsg_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    // Register offsets.
    localparam logic [8:0] ADDR_LINE_EXT = 9'h001;
    localparam logic [8:0] ADDR_ROI = 9'h003;
    localparam logic [8:0] ADDR_BLACK = 9'h005;
    localparam logic [8:0] ADDR_FILLER = 9'h006;
    localparam logic [8:0] ADDR_EXPO = 9'h009;
    localparam logic [8:0] ADDR_EXPO_DS = 9'h00A;
    localparam logic [8:0] ADDR_EXPO_TS = 9'h00B;
    localparam logic [8:0] ADDR_GAIN = 9'h00C;
    localparam logic [8:0] ADDR_DGAIN = 9'h00D;
    localparam logic [8:0] ADDR_LATCH = 9'h00E;
    localparam logic [8:0] ADDR_GAIN_STAT = 9'h015;
    localparam logic [8:0] ADDR_DGAIN_STAT = 9'h016;

    // Reset values.
    localparam logic [15:0] RST_LINE_EXT = 16'h0000;
    localparam logic [15:0] RST_ROI = 16'h0001;
    localparam logic [15:0] RST_BLACK = 16'h0102;
    localparam logic [15:0] RST_FILLER = 16'h0000;
    localparam logic [15:0] RST_EXPO = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h01E2;
    localparam logic [15:0] RST_DGAIN = 16'h0080;
    localparam logic [15:0] RST_LATCH = 16'h033F;

    // Implemented bits; the rest read as zero.
    localparam logic [15:0] MASK_LINE_EXT = 16'hFFFF;
    localparam logic [15:0] MASK_ROI = 16'h00FF;
    localparam logic [15:0] MASK_BLACK = 16'h01FF;
    localparam logic [15:0] MASK_FILLER = 16'h0FFF;
    localparam logic [15:0] MASK_EXPO = 16'hFFFF;
    localparam logic [15:0] MASK_GAIN = 16'h21E3;
    localparam logic [15:0] MASK_DGAIN = 16'h0FFF;
    localparam logic [15:0] MASK_LATCH = 16'h073F;

    // Field positions.
    localparam int G1_LSB = 0;
    localparam int G1_W = 2;
    localparam int G2_LSB = 5;
    localparam int G2_W = 4;
    localparam int POSTPONE_BIT = 13;
    localparam int DG_W = 12;
    localparam int LINE_EXT_W = 8;
    localparam int ROI_W = 8;
    localparam int BLACK_W = 9;
    localparam int FILLER_W = 12;
    localparam int EXPO_W = 16;

    // Frame latch control bits.
    localparam int HOLD_LINE_EXT_BIT = 0;
    localparam int HOLD_BLACK_BIT = 1;
    localparam int HOLD_FILLER_BIT = 2;
    localparam int HOLD_EXPO_BIT = 3;
    localparam int HOLD_GAIN_BIT = 4;
    localparam int HOLD_ROI_BIT = 5;
    localparam int BLANK_ROI_BIT = 8;
    localparam int BLANK_SUBSAMPLE_BIT = 9;
    localparam int EXPO_FREE_BIT = 10;

    typedef struct packed {
        logic [1:0] analog_gain_first;
        logic [3:0] analog_gain_second;
        logic [11:0] digital_gain_factor;
    } fsg_gain_s;

    typedef struct packed {
        logic [7:0] rolling_line_extension;
        logic [7:0] roi_select;
        logic [8:0] dark_rows;
        logic [11:0] filler_rows;
        logic [15:0] exposure;
        logic [15:0] exposure_ds;
        logic [15:0] exposure_ts;
        fsg_gain_s gain;
    } fsg_active_s;
endpackage

//--- hw/fsg_shadow.sv
// One active copy of a setting, loaded from its written value.
`timescale 1ns/1ps
module fsg_shadow #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hold,
    input wire logic load,
    input wire logic [W-1:0] src,
    output logic [W-1:0] active_q
);
    // Follows the written value unless held, then only on the load pulse.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active_q <= RST;
        end
        else if (load || !hold)
        begin
            active_q <= src;
        end
    end
endmodule

//--- hw/fsg_config_bank.sv
// Gain and frame-latch configuration bank with frame-synchronised active copies.
// Contract
// - Postpone flag set: gain write applies one frame later than normal.
// - Postpone flag clear: gain write applies at the next frame start.
// - Bit 0 set holds line extension to frame start; clear applies at once.
// - Bits 1, 2, 4 hold dark rows, filler rows, gain to frame start.
// - Bit 3 set holds exposure for a sync point; clear applies at once.
// - Bit 5 set holds region selection change to frame start.
// - Bit 8 set blanks first frame after region selection change.
// - Blank first frame after subsampling change: bit 9 global, always rolling.
// - Latch policy bit zero: exposure transfers at overhead-time start.
// - Latch policy bit one: exposure passes through continuously.
`timescale 1ns/1ps
module fsg_config_bank (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic reg_wr_en,
    input wire logic [8:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data_q,
    input wire logic frame_start,
    input wire logic frame_overhead_time_start,
    input wire logic rolling_shutter,
    input wire logic subsample_switch,
    output fsg_pkg::fsg_active_s active_q,
    output logic blank_frame_q
);
    logic [15:0] line_ext_q;
    logic [15:0] roi_q;
    logic [15:0] black_q;
    logic [15:0] filler_q;
    logic [15:0] expo_q;
    logic [15:0] expo_ds_q;
    logic [15:0] expo_ts_q;
    logic [15:0] gain_q;
    logic [15:0] dgain_q;
    logic [15:0] latch_q;
    logic [15:0] rd_d;
    fsg_pkg::fsg_gain_s gain_src;
    fsg_pkg::fsg_gain_s gain_mid_q;
    fsg_pkg::fsg_gain_s gain_act_q;
    logic expo_hold;
    logic roi_upd;
    logic roi_sw;
    logic ss_sw;
    logic blank_arm_q;

    // Written values; each register keeps only its implemented bits.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_ext_q <= fsg_pkg::RST_LINE_EXT;
            roi_q <= fsg_pkg::RST_ROI;
            black_q <= fsg_pkg::RST_BLACK;
            filler_q <= fsg_pkg::RST_FILLER;
            expo_q <= fsg_pkg::RST_EXPO;
            expo_ds_q <= fsg_pkg::RST_EXPO;
            expo_ts_q <= fsg_pkg::RST_EXPO;
            gain_q <= fsg_pkg::RST_GAIN;
            dgain_q <= fsg_pkg::RST_DGAIN;
            latch_q <= fsg_pkg::RST_LATCH;
        end
        else if (reg_wr_en)
        begin
            unique case (reg_addr)
                fsg_pkg::ADDR_LINE_EXT: line_ext_q <= reg_wr_data & fsg_pkg::MASK_LINE_EXT;
                fsg_pkg::ADDR_ROI: roi_q <= reg_wr_data & fsg_pkg::MASK_ROI;
                fsg_pkg::ADDR_BLACK: black_q <= reg_wr_data & fsg_pkg::MASK_BLACK;
                fsg_pkg::ADDR_FILLER: filler_q <= reg_wr_data & fsg_pkg::MASK_FILLER;
                fsg_pkg::ADDR_EXPO: expo_q <= reg_wr_data & fsg_pkg::MASK_EXPO;
                fsg_pkg::ADDR_EXPO_DS: expo_ds_q <= reg_wr_data & fsg_pkg::MASK_EXPO;
                fsg_pkg::ADDR_EXPO_TS: expo_ts_q <= reg_wr_data & fsg_pkg::MASK_EXPO;
                fsg_pkg::ADDR_GAIN: gain_q <= reg_wr_data & fsg_pkg::MASK_GAIN;
                fsg_pkg::ADDR_DGAIN: dgain_q <= reg_wr_data & fsg_pkg::MASK_DGAIN;
                fsg_pkg::ADDR_LATCH: latch_q <= reg_wr_data & fsg_pkg::MASK_LATCH;
                default: ;
            endcase
        end
    end

    // Readback of written values and of the gain in use.
    always_comb
    begin
        rd_d = '0;
        unique case (reg_addr)
            fsg_pkg::ADDR_LINE_EXT: rd_d = line_ext_q;
            fsg_pkg::ADDR_ROI: rd_d = roi_q;
            fsg_pkg::ADDR_BLACK: rd_d = black_q;
            fsg_pkg::ADDR_FILLER: rd_d = filler_q;
            fsg_pkg::ADDR_EXPO: rd_d = expo_q;
            fsg_pkg::ADDR_EXPO_DS: rd_d = expo_ds_q;
            fsg_pkg::ADDR_EXPO_TS: rd_d = expo_ts_q;
            fsg_pkg::ADDR_GAIN: rd_d = gain_q;
            fsg_pkg::ADDR_DGAIN: rd_d = dgain_q;
            fsg_pkg::ADDR_LATCH: rd_d = latch_q;
            fsg_pkg::ADDR_GAIN_STAT:
            begin
                rd_d[fsg_pkg::G1_LSB +: fsg_pkg::G1_W] = gain_act_q.analog_gain_first;
                rd_d[fsg_pkg::G2_LSB +: fsg_pkg::G2_W] = gain_act_q.analog_gain_second;
            end
            fsg_pkg::ADDR_DGAIN_STAT: rd_d[fsg_pkg::DG_W-1:0] = gain_act_q.digital_gain_factor;
            default: rd_d = '0;
        endcase
    end

    // Read data are registered, so they appear one edge after the address.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rd_data_q <= '0;
        end
        else
        begin
            reg_rd_data_q <= rd_d;
        end
    end

    fsg_shadow #(.W(fsg_pkg::LINE_EXT_W), .RST(fsg_pkg::RST_LINE_EXT[fsg_pkg::LINE_EXT_W-1:0])) u_line_ext (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hold(latch_q[fsg_pkg::HOLD_LINE_EXT_BIT]),
        .load(frame_start),
        .src(line_ext_q[fsg_pkg::LINE_EXT_W-1:0]),
        .active_q(active_q.rolling_line_extension)
    );

    fsg_shadow #(.W(fsg_pkg::BLACK_W), .RST(fsg_pkg::RST_BLACK[fsg_pkg::BLACK_W-1:0])) u_black (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hold(latch_q[fsg_pkg::HOLD_BLACK_BIT]),
        .load(frame_start),
        .src(black_q[fsg_pkg::BLACK_W-1:0]),
        .active_q(active_q.dark_rows)
    );

    fsg_shadow #(.W(fsg_pkg::FILLER_W), .RST(fsg_pkg::RST_FILLER[fsg_pkg::FILLER_W-1:0])) u_filler (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hold(latch_q[fsg_pkg::HOLD_FILLER_BIT]),
        .load(frame_start),
        .src(filler_q[fsg_pkg::FILLER_W-1:0]),
        .active_q(active_q.filler_rows)
    );

    fsg_shadow #(.W(fsg_pkg::ROI_W), .RST(fsg_pkg::RST_ROI[fsg_pkg::ROI_W-1:0])) u_roi (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hold(latch_q[fsg_pkg::HOLD_ROI_BIT]),
        .load(frame_start),
        .src(roi_q[fsg_pkg::ROI_W-1:0]),
        .active_q(active_q.roi_select)
    );

    // exposure holds only while bit 3 is set and the policy bit clear.
    assign expo_hold = latch_q[fsg_pkg::HOLD_EXPO_BIT] && !latch_q[fsg_pkg::EXPO_FREE_BIT];

    // three exposure copies share the overhead-time pulse.
    fsg_shadow #(.W(fsg_pkg::EXPO_W), .RST(fsg_pkg::RST_EXPO)) u_expo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hold(expo_hold),
        .load(frame_overhead_time_start),
        .src(expo_q),
        .active_q(active_q.exposure)
    );
    fsg_shadow #(.W(fsg_pkg::EXPO_W), .RST(fsg_pkg::RST_EXPO)) u_expo_ds (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hold(expo_hold),
        .load(frame_overhead_time_start),
        .src(expo_ds_q),
        .active_q(active_q.exposure_ds)
    );
    fsg_shadow #(.W(fsg_pkg::EXPO_W), .RST(fsg_pkg::RST_EXPO)) u_expo_ts (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hold(expo_hold),
        .load(frame_overhead_time_start),
        .src(expo_ts_q),
        .active_q(active_q.exposure_ts)
    );

    // Gain fields gathered from the two written gain words.
    always_comb
    begin
        gain_src.analog_gain_first = gain_q[fsg_pkg::G1_LSB +: fsg_pkg::G1_W];
        gain_src.analog_gain_second = gain_q[fsg_pkg::G2_LSB +: fsg_pkg::G2_W];
        gain_src.digital_gain_factor = dgain_q[fsg_pkg::DG_W-1:0];
    end

    // The middle stage captures the gain at each frame start, one frame ahead.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gain_mid_q <= fsg_pkg::fsg_gain_s'({fsg_pkg::RST_GAIN[fsg_pkg::G1_LSB +: fsg_pkg::G1_W],
                fsg_pkg::RST_GAIN[fsg_pkg::G2_LSB +: fsg_pkg::G2_W], fsg_pkg::RST_DGAIN[fsg_pkg::DG_W-1:0]});
        end
        else if (frame_start)
        begin
            gain_mid_q <= gain_src;
        end
    end

    // gain applies at once when its hold bit is clear.
    // postponed gain comes from the middle stage, else from the written value.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gain_act_q <= fsg_pkg::fsg_gain_s'({fsg_pkg::RST_GAIN[fsg_pkg::G1_LSB +: fsg_pkg::G1_W],
                fsg_pkg::RST_GAIN[fsg_pkg::G2_LSB +: fsg_pkg::G2_W], fsg_pkg::RST_DGAIN[fsg_pkg::DG_W-1:0]});
        end
        else if (!latch_q[fsg_pkg::HOLD_GAIN_BIT])
        begin
            gain_act_q <= gain_src;
        end
        else if (frame_start)
        begin
            gain_act_q <= gain_q[fsg_pkg::POSTPONE_BIT] ? gain_mid_q : gain_src;
        end
    end

    assign active_q.gain = gain_act_q;

    // a region change is seen the cycle the active selection takes it.
    assign roi_upd = frame_start || !latch_q[fsg_pkg::HOLD_ROI_BIT];
    assign roi_sw = roi_upd && (roi_q[fsg_pkg::ROI_W-1:0] != active_q.roi_select)
        && latch_q[fsg_pkg::BLANK_ROI_BIT];
    // rolling shutter always blanks; global only with bit 9.
    assign ss_sw = subsample_switch && (rolling_shutter || latch_q[fsg_pkg::BLANK_SUBSAMPLE_BIT]);

    // a switch arms blanking for the next frame; a switch at frame start
    // blanks the frame now starting, since that is the first one to use it.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            blank_arm_q <= 1'b0;
            blank_frame_q <= 1'b0;
        end
        else if (frame_start)
        begin
            blank_arm_q <= 1'b0;
            blank_frame_q <= blank_arm_q || roi_sw || ss_sw;
        end
        else
        begin
            blank_arm_q <= blank_arm_q || roi_sw || ss_sw;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence seq_gain_defer;
        frame_start && latch_q[fsg_pkg::HOLD_GAIN_BIT] && gain_q[fsg_pkg::POSTPONE_BIT];
    endsequence

    // postponed gain takes the value captured a frame earlier.
    chk_gain_postpone:
    assert property (seq_gain_defer |=> gain_act_q == $past(gain_mid_q))
    else $error("postponed gain not taken from previous frame capture");

    // plain synchronised gain takes the written value.
    chk_gain_next_frame:
    assert property ((frame_start && latch_q[fsg_pkg::HOLD_GAIN_BIT] && !gain_q[fsg_pkg::POSTPONE_BIT])
        |=> gain_act_q == $past(gain_src))
    else $error("gain not applied at frame start");

    // held gain does not move between frame starts.
    chk_gain_hold:
    assert property ((latch_q[fsg_pkg::HOLD_GAIN_BIT] && !frame_start) |=> $stable(gain_act_q))
    else $error("held gain changed outside frame start");

    // unheld line extension follows the write within one cycle.
    chk_line_ext_free:
    assert property (!latch_q[fsg_pkg::HOLD_LINE_EXT_BIT]
        |=> active_q.rolling_line_extension == $past(line_ext_q[fsg_pkg::LINE_EXT_W-1:0]))
    else $error("line extension not applied at once");

    // held filler rows wait for frame start.
    chk_filler_hold:
    assert property ((latch_q[fsg_pkg::HOLD_FILLER_BIT] && !frame_start) |=> $stable(active_q.filler_rows))
    else $error("held filler rows changed");

    // held region selection waits for frame start.
    chk_roi_hold:
    assert property ((latch_q[fsg_pkg::HOLD_ROI_BIT] && !frame_start) |=> $stable(active_q.roi_select))
    else $error("held region selection changed");

    // held exposure loads the written value on the overhead-time pulse.
    chk_expo_overhead:
    assert property (expo_hold |=> (active_q.exposure == $past(expo_q)) || !$past(frame_overhead_time_start))
    else $error("exposure not loaded at overhead time");

    sequence seq_expo_still;
        expo_hold && !frame_overhead_time_start;
    endsequence

    // held exposure does not move without the sync pulse.
    chk_expo_hold:
    assert property (seq_expo_still |=> $stable(active_q.exposure))
    else $error("held exposure changed");

    chk_expo_free:
    assert property (latch_q[fsg_pkg::EXPO_FREE_BIT] |=> active_q.exposure == $past(expo_q))
    else $error("free exposure not passed through");

    // a region switch away from frame start arms blanking for the next frame.
    chk_blank_region:
    assert property ((roi_sw && !frame_start) |=> blank_arm_q)
    else $error("region switch did not arm blanking");

    sequence seq_arm_at_frame;
        blank_arm_q && frame_start;
    endsequence

    // an armed switch blanks the frame that starts next, however long the wait.
    chk_blank_armed:
    assert property (seq_arm_at_frame |=> blank_frame_q)
    else $error("armed frame not blanked");

    // rolling shutter subsampling switch away from frame start always arms blanking.
    chk_blank_rolling:
    assert property ((subsample_switch && rolling_shutter && !frame_start) |=> blank_arm_q)
    else $error("rolling subsampling switch did not arm blanking");
endmodule

//--- verif/tb.sv
// Self-checking testbench for the frame-synchronised gain configuration bank.
`timescale 1ns/1ps
module tb;
    logic core_clk;
    logic arst_n;
    logic reg_wr_en;
    logic [8:0] reg_addr;
    logic [15:0] reg_wr_data;
    logic [15:0] reg_rd_data_q;
    logic frame_start;
    logic frame_overhead_time_start;
    logic rolling_shutter;
    logic subsample_switch;
    fsg_pkg::fsg_active_s active_q;
    logic blank_frame_q;
    int error_cnt;
    int checks_done;
    logic [15:0] rd_val;
    logic [15:0] blank_latch [3] = '{16'h0200, 16'h0000, 16'h0000};
    logic blank_roll [3] = '{1'b0, 1'b1, 1'b0};
    logic blank_exp [3] = '{1'b1, 1'b1, 1'b0};

    fsg_config_bank dut_u (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data),
        .reg_rd_data_q(reg_rd_data_q),
        .frame_start(frame_start),
        .frame_overhead_time_start(frame_overhead_time_start),
        .rolling_shutter(rolling_shutter),
        .subsample_switch(subsample_switch),
        .active_q(active_q),
        .blank_frame_q(blank_frame_q)
    );

    // Free-running 40 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Prints the verdict and stops the run; the only exit point.
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One-cycle write strobe; the strobe drops on the following edge.
    task automatic wr(input logic [8:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= addr;
        reg_wr_data <= data;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask

    // Read data is registered, so it is taken one edge after the address.
    task automatic rd(input logic [8:0] addr, output logic [15:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        @(posedge core_clk);
        @(negedge core_clk);
        data = reg_rd_data_q;
    endtask

    // Sequencer pulses: 0 frame start, 1 overhead start, 2 subsampling switch.
    task automatic pulse(input int sel);
        @(posedge core_clk);
        if (sel == 0) frame_start <= 1'b1;
        if (sel == 1) frame_overhead_time_start <= 1'b1;
        if (sel == 2) subsample_switch <= 1'b1;
        @(posedge core_clk);
        frame_start <= 1'b0;
        frame_overhead_time_start <= 1'b0;
        subsample_switch <= 1'b0;
        @(negedge core_clk);
    endtask

    // Bounds the run well above the 138 cycles the sequence needs.
    initial
    begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end

    // Main sequence.
    initial
    begin
        error_cnt = 0;
        checks_done = 0;
        arst_n = 1'b0;
        reg_wr_en = 1'b0;
        reg_addr = 9'h000;
        reg_wr_data = 16'h0000;
        frame_start = 1'b0;
        frame_overhead_time_start = 1'b0;
        rolling_shutter = 1'b0;
        subsample_switch = 1'b0;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, and an unmapped place that ignores writes.
        rd(fsg_pkg::ADDR_GAIN, rd_val);
        chk("gain word reset", rd_val, 16'h01E2);
        rd(fsg_pkg::ADDR_DGAIN, rd_val);
        chk("digital gain reset", rd_val, 16'h0080);
        rd(fsg_pkg::ADDR_LATCH, rd_val);
        chk("latch control reset", rd_val, 16'h033F);
        wr(9'h004, 16'hFFFF);
        rd(9'h004, rd_val);
        chk("unmapped read", rd_val, 16'h0000);
        chk("active gain second reset", {12'h000, active_q.gain.analog_gain_second}, 16'h000F);
        chk("dark rows reset", {7'h00, active_q.dark_rows}, 16'h0102);
        chk("roi reset", {8'h00, active_q.roi_select}, 16'h0001);
        // Gain write without postpone lands at the next frame start.
        wr(fsg_pkg::ADDR_GAIN, 16'h0061);
        idle(3);
        chk("gain held", {14'h0000, active_q.gain.analog_gain_first}, 16'h0002);
        pulse(0);
        idle(2);
        chk("gain first", {14'h0000, active_q.gain.analog_gain_first}, 16'h0001);
        chk("gain second", {12'h000, active_q.gain.analog_gain_second}, 16'h0003);
        rd(fsg_pkg::ADDR_GAIN_STAT, rd_val);
        chk("gain status", rd_val, 16'h0061);
        // Postponed gain waits for a second frame start.
        wr(fsg_pkg::ADDR_GAIN, 16'h2022);
        pulse(0);
        idle(2);
        chk("gain postponed", {14'h0000, active_q.gain.analog_gain_first}, 16'h0001);
        pulse(0);
        idle(2);
        chk("gain after postpone", {14'h0000, active_q.gain.analog_gain_first}, 16'h0002);
        chk("gain second postpone", {12'h000, active_q.gain.analog_gain_second}, 16'h0001);
        // Line extension held, then free.
        wr(fsg_pkg::ADDR_LINE_EXT, 16'h0012);
        idle(3);
        chk("line ext held", {8'h00, active_q.rolling_line_extension}, 16'h0000);
        pulse(0);
        idle(2);
        chk("line ext at frame", {8'h00, active_q.rolling_line_extension}, 16'h0012);
        wr(fsg_pkg::ADDR_LATCH, 16'h033E);
        wr(fsg_pkg::ADDR_LINE_EXT, 16'h0034);
        idle(3);
        chk("line ext free", {8'h00, active_q.rolling_line_extension}, 16'h0034);
        // Dark rows, filler rows and gain free; exposure still held.
        wr(fsg_pkg::ADDR_LATCH, 16'h0328);
        wr(fsg_pkg::ADDR_BLACK, 16'h0005);
        wr(fsg_pkg::ADDR_FILLER, 16'h0ABC);
        wr(fsg_pkg::ADDR_GAIN, 16'h0041);
        wr(fsg_pkg::ADDR_DGAIN, 16'h0123);
        idle(3);
        chk("dark rows free", {7'h00, active_q.dark_rows}, 16'h0005);
        chk("filler rows free", {4'h0, active_q.filler_rows}, 16'h0ABC);
        chk("gain second free", {12'h000, active_q.gain.analog_gain_second}, 16'h0002);
        chk("digital gain free", {4'h0, active_q.gain.digital_gain_factor}, 16'h0123);
        rd(fsg_pkg::ADDR_DGAIN_STAT, rd_val);
        chk("digital gain status", rd_val, 16'h0123);
        // Held exposure ignores frame start and loads on overhead start.
        wr(fsg_pkg::ADDR_EXPO, 16'h1234);
        wr(fsg_pkg::ADDR_EXPO_DS, 16'h2345);
        wr(fsg_pkg::ADDR_EXPO_TS, 16'h3456);
        pulse(0);
        idle(2);
        chk("exposure held", active_q.exposure, 16'h0000);
        chk("exposure ds held", active_q.exposure_ds, 16'h0000);
        pulse(1);
        idle(2);
        chk("exposure at overhead", active_q.exposure, 16'h1234);
        chk("exposure ds at overhead", active_q.exposure_ds, 16'h2345);
        chk("exposure ts at overhead", active_q.exposure_ts, 16'h3456);
        // Global shutter stays selected from reset, the only mode where the policy bit may be set.
        wr(fsg_pkg::ADDR_LATCH, 16'h0728);
        wr(fsg_pkg::ADDR_EXPO, 16'h5678);
        idle(3);
        chk("exposure pass through", active_q.exposure, 16'h5678);
        wr(fsg_pkg::ADDR_LATCH, 16'h0320);
        wr(fsg_pkg::ADDR_EXPO, 16'h0F0F);
        idle(3);
        chk("exposure free", active_q.exposure, 16'h0F0F);
        // Held region change with blanking of its first frame.
        wr(fsg_pkg::ADDR_ROI, 16'h0005);
        idle(3);
        chk("roi held", {8'h00, active_q.roi_select}, 16'h0001);
        pulse(0);
        chk("roi at frame", {8'h00, active_q.roi_select}, 16'h0005);
        chk("roi blank", {15'h0000, blank_frame_q}, 16'h0001);
        pulse(0);
        chk("roi blank ends", {15'h0000, blank_frame_q}, 16'h0000);
        // Free region change without blanking.
        wr(fsg_pkg::ADDR_LATCH, 16'h0200);
        wr(fsg_pkg::ADDR_ROI, 16'h000A);
        idle(3);
        chk("roi free", {8'h00, active_q.roi_select}, 16'h000A);
        pulse(0);
        chk("roi no blank", {15'h0000, blank_frame_q}, 16'h0000);
        // Subsampling switch: bit 9 in global mode, always in rolling mode.
        for (int i = 0; i < 3; i++)
        begin
            wr(fsg_pkg::ADDR_LATCH, blank_latch[i]);
            rolling_shutter <= blank_roll[i];
            pulse(2);
            pulse(0);
            chk("subsample blank", {15'h0000, blank_frame_q}, {15'h0000, blank_exp[i]});
            pulse(0);
            chk("subsample blank ends", {15'h0000, blank_frame_q}, 16'h0000);
        end
        close_out();
    end
endmodule
